// *** dv/tb_xor_and_stack_op_decoder.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_xor_and_stack_op_decoder;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic ext_on = 1'b1;
    logic [31:0] r;
    int n_errors = 0;
    int num_checks = 0;
    int cycles = 0;
    xor_and_stack_op_decoder dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
    always #5 hclk = ~hclk;
    task automatic final_report();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 8000) begin
            n_errors++;
            final_report();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic rdy();
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask
    task automatic addr(input logic w, input logic [7:0] a);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        addr(1'b1, a);
        rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        rdy();
    endtask
    task automatic rv(input logic [7:0] a, output logic [31:0] d);
        addr(1'b0, a);
        rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        rdy();
        d = hrdata;
    endtask
    task automatic rm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] v;
        rv(a, v);
        check(v & m, e);
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        rm(a, 32'hFFFF_FFFF, e);
    endtask
    // Read address phase overlaps the write data phase to force the wait state
    task automatic wr_rd(input logic [7:0] a, input logic [31:0] d);
        addr(1'b1, a);
        rdy();
        addr(1'b0, a);
        hwdata <= d;
        rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        rdy();
        check(hrdata, d);
    endtask
    task automatic ms(input logic [7:0] i, input logic [7:0] v);
        wr(8'h28, {24'h0, i});
        wr(8'h2C, {24'h0, v});
    endtask
    task automatic mc(input logic [7:0] i, input logic [31:0] e);
        wr(8'h28, {24'h0, i});
        rc(8'h2C, e);
    endtask
    task automatic run(input logic [31:0] ins);
        wr(8'h04, ins);
        wr(8'h00, {30'h0, ext_on, 1'b1});
        repeat (30) begin
            rv(8'h00, r);
            if (r[0] === 1'b0)
                break;
        end
        check({31'h0, r[0]}, 32'h0);
    endtask
    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        rc(8'h00, 32'h2);
        rc(8'h3C, 32'h0);
        wr_rd(8'h08, 32'h5A);
        $display("test reset and bus done");
        wr(8'h0C, 32'h1);
        wr(8'h08, 32'hB5);
        ms(8'h20, 8'hAF);
        wr(8'h1C, 32'h1F);
        run(32'h1B20);
        mc(8'h20, 32'h1A);
        rc(8'h08, 32'hB5);
        rc(8'h1C, 32'h0B);
        rc(8'h30, 32'h0120_0010);
        wr(8'h18, 32'h10);
        wr(8'h08, 32'hFF);
        ms(8'h15, 8'hFF);
        wr(8'h1C, 32'h0);
        run(32'h1805);
        rc(8'h08, 32'h0);
        rc(8'h1C, 32'h4);
        rc(8'h30, 32'h0015_0010);
        run(32'h1880);
        rm(8'h30, 32'h0FFF_0000, 32'h0F80_0000);
        $display("test xor done");
        wr(8'h1C, 32'h1F);
        for (int i = 0; i < 3; i++) begin
            wr(8'h10 + 8'(4 * i), 32'h3FF);
            run({16'h0, 8'hE8, i[1:0], 6'h23});
            rc(8'h10 + 8'(4 * i), 32'h422);
            run({16'h0, 8'hE9, i[1:0], 6'h3F});
            rc(8'h10 + 8'(4 * i), 32'h3E3);
        end
        rc(8'h1C, 32'h1F);
        wr(8'h24, 32'h1234);
        wr(8'h18, 32'h100);
        run(32'hE8C5);
        rc(8'h18, 32'h105);
        rc(8'h20, 32'h1234);
        rm(8'h30, 32'hFF, 32'h40);
        run(32'hE9C1);
        rc(8'h18, 32'h104);
        rm(8'h30, 32'hFF, 32'h50);
        $display("test pointer ops done");
        wr(8'h08, 32'h56);
        wr(8'h34, 32'h312);
        wr(8'h20, 32'h200);
        run(32'h0014);
        rc(8'h20, 32'h31256);
        rc(8'h24, 32'h202);
        wr(8'h18, 32'h40);
        run(32'hEA77);
        mc(8'h40, 32'h77);
        rc(8'h18, 32'h3F);
        ms(8'h44, 8'h99);
        wr(8'h20, 32'h300);
        run(32'hF080_EB05);
        mc(8'h80, 32'h99);
        rc(8'h20, 32'h304);
        run(32'hF003_EB85);
        mc(8'h42, 32'h99);
        ms(8'h42, 8'h0);
        run(32'hA003_EB85);
        mc(8'h42, 32'h0);
        rm(8'h30, 32'h3, 32'h2);
        run(32'hEC00);
        rm(8'h30, 32'hFF, 32'h2);
        $display("test call push move done");
        ext_on = 1'b0;
        wr(8'h10, 32'h3FF);
        wr(8'h20, 32'h500);
        run(32'hE810);
        rc(8'h00, 32'h0);
        rc(8'h10, 32'h3FF);
        rc(8'h20, 32'h502);
        rm(8'h30, 32'hFF, 32'h2);
        wr(8'h08, 32'h80);
        ms(8'h05, 8'h0);
        wr(8'h1C, 32'h0);
        run(32'h1805);
        rc(8'h08, 32'h80);
        rc(8'h1C, 32'h10);
        rm(8'h30, 32'h0FFF_0000, 32'h0005_0000);
        $display("test extended off done");
        final_report();
    end
endmodule
`default_nettype wire

// *** dv/xdec_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module xdec_monitor (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp
);
    logic acc;
    logic rd_ph;
    logic wr_ph;
    logic ext_last;
    logic ctrl_seen;
    logic [7:0] ph_addr;
    logic [4:0] go_age;
    assign acc = hsel && htrans[1] && hready;
    // Phase flags hold through a wait state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_ph <= 1'b0;
            wr_ph <= 1'b0;
            ph_addr <= 8'h00;
        end else if (hready) begin
            rd_ph <= acc && !hwrite;
            wr_ph <= acc && hwrite;
            ph_addr <= haddr[7:0];
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ext_last <= 1'b1;
            ctrl_seen <= 1'b0;
        end else if (wr_ph && hready && ph_addr == 8'h00) begin
            ext_last <= hwdata[1];
            ctrl_seen <= 1'b1;
        end
    end
    // Saturates so an old go never looks recent
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            go_age <= 5'h1F;
        else if (wr_ph && hready && ph_addr == 8'h00 && hwdata[0])
            go_age <= 5'h00;
        else if (go_age != 5'h1F)
            go_age <= go_age + 5'h01;
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    chk_resp_okay: assert property (hresp == 1'b0)
        else $error("response not okay");
    chk_wait_after_write: assert property (acc && !hwrite && wr_ph |=> !hreadyout ##1 hreadyout)
        else $error("read after write wait wrong");
    chk_no_wait_plain: assert property (acc && !(!hwrite && wr_ph) |=> hreadyout)
        else $error("unexpected wait state");
    chk_unmapped_zero: assert property (rd_ph && hreadyout && (ph_addr > 8'h34 || ph_addr[1:0] != 2'h0)
        |-> hrdata == 32'h0)
        else $error("unmapped read not zero");
    chk_ext_reset_on: assert property (
        rd_ph && hreadyout && ph_addr == 8'h00 && !ctrl_seen |-> hrdata[1])
        else $error("extended set off after reset");
    chk_ext_follows_cfg: assert property (
        rd_ph && hreadyout && ph_addr == 8'h00 |-> hrdata[1] == ext_last)
        else $error("extended enable readback wrong");
    chk_busy_bounded: assert property (
        rd_ph && hreadyout && ph_addr == 8'h00 && go_age > 5'h08 |-> !hrdata[0])
        else $error("busy too long");
    chk_rdata_hold: assert property (!(acc && !hwrite) && !(rd_ph && !hreadyout) |=> $stable(hrdata))
        else $error("read data changed without read");
    cover property (acc && !hwrite && wr_ph);
    cover property (wr_ph && hready && ph_addr == 8'h00 && hwdata[0]);
    cover property (rd_ph && hreadyout && ph_addr == 8'h00 && !hrdata[1]);
endmodule
bind xor_and_stack_op_decoder xdec_monitor mon_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp));
`default_nettype wire

// *** verilog/decode_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface decode_if;
    import xdec_pkg::*;
    logic [15:0] instr;
    logic [15:0] instr2;
    logic ext_en;
    op_t op;
    logic dest_file;
    logic bank_sel;
    logic [7:0] faddr;
    logic [1:0] psel;
    logic [5:0] lit6;
    logic [7:0] lit8;
    logic [6:0] zsrc;
    logic [6:0] zdst;
    logic [11:0] fdst;
    logic second_ok;
    logic two_cycle;
    modport dec(input instr, instr2, ext_en, output op, dest_file, bank_sel, faddr, psel, lit6, lit8,
        zsrc, zdst, fdst, second_ok, two_cycle);
    modport core(output instr, instr2, ext_en, input op, dest_file, bank_sel, faddr, psel, lit6, lit8,
        zsrc, zdst, fdst, second_ok, two_cycle);
endinterface
`default_nettype wire

// *** verilog/op_decoder.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "xdec_cfg.svh"
module op_decoder import xdec_pkg::*; (
    decode_if.dec d
);
    always_comb begin
        d.op = op_unsupported;
        d.dest_file = d.instr[9];
        d.bank_sel = d.instr[8];
        d.faddr = d.instr[7:0];
        d.psel = d.instr[7:6];
        d.lit6 = d.instr[5:0];
        d.lit8 = d.instr[7:0];
        d.zsrc = d.instr[6:0];
        d.zdst = d.instr2[6:0];
        d.fdst = d.instr2[11:0];
        d.second_ok = (d.instr2[15:12] == `SECOND_PFX);
        if (d.instr[15:10] == `OPC_XOR) begin
            d.op = xor_w_into_file;
        end else if (d.ext_en) begin
            if (d.instr == `OPC_CALL_VIA_WORKING_REG) begin
                d.op = call_via_working_reg;
            end else begin
                unique case (d.instr[15:8])
                    `OPC_PADD: d.op = (d.psel == `PSEL_RET) ? stack_pointer_add_and_return
                        : pointer_add_literal;
                    `OPC_PSUB: d.op = (d.psel == `PSEL_RET) ? stack_pointer_sub_and_return
                        : pointer_sub_literal;
                    `OPC_PUSH: d.op = push_literal_to_soft_stack;
                    `OPC_MOVS: d.op = d.instr[7] ? indexed_to_indexed_move
                        : indexed_to_absolute_move;
                    default: d.op = op_unsupported;
                endcase
            end
        end
        d.two_cycle = (d.op == stack_pointer_add_and_return) || (d.op == stack_pointer_sub_and_return)
            || (d.op == call_via_working_reg) || (d.op == indexed_to_absolute_move)
            || (d.op == indexed_to_indexed_move);
    end
endmodule
`default_nettype wire

// *** verilog/xdec_cfg.svh ***
`ifndef XDEC_CFG_SVH
`define XDEC_CFG_SVH
`define R_CTRL 8'h00
`define R_INSTR 8'h04
`define R_WORKING_REGISTER 8'h08
`define R_BSR 8'h0C
`define R_FSR0 8'h10
`define R_STATUS 8'h1C
`define R_PC 8'h20
`define R_TOS 8'h24
`define R_MADDR 8'h28
`define R_MDATA 8'h2C
`define R_EXEC 8'h30
`define R_PCLAT 8'h34
`define CTRL_GO 0
`define CTRL_XCFG 1
`define XCFG_RESET 1'b1
`define ST_N 4
`define ST_Z 2
`define ACC_LIMIT 8'h5F
`define SFR_BANK 4'hF
`define OPC_XOR 6'h06
`define OPC_PADD 8'hE8
`define OPC_PSUB 8'hE9
`define OPC_PUSH 8'hEA
`define OPC_MOVS 8'hEB
`define OPC_CALL_VIA_WORKING_REG 16'h0014
`define SECOND_PFX 4'hF
`define PSEL_RET 2'h3
`define PTR_STACK 2
`define PC_STEP 21'h000002
`define PC_STEP2 21'h000004
`define LAST_PHASE 2'h3
`endif

// *** verilog/xdec_pkg.sv ***
package xdec_pkg;
    typedef enum logic [3:0] {
        op_unsupported = 4'h0,
        xor_w_into_file = 4'h1,
        pointer_add_literal = 4'h2,
        pointer_sub_literal = 4'h3,
        stack_pointer_add_and_return = 4'h4,
        stack_pointer_sub_and_return = 4'h5,
        call_via_working_reg = 4'h6,
        indexed_to_absolute_move = 4'h7,
        indexed_to_indexed_move = 4'h8,
        push_literal_to_soft_stack = 4'h9
    } op_t;
    typedef enum logic [1:0] {
        st_idle = 2'b00,
        st_cyc1 = 2'b01,
        st_cyc2 = 2'b10
    } exec_state_t;
endpackage

// *** verilog/xor_and_stack_op_decoder.sv ***
// Implementation choices: register access over AHB-Lite and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "xdec_cfg.svh"
module xor_and_stack_op_decoder import xdec_pkg::*; (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp
);
    decode_if dif();

    logic [1:0] phase;
    logic ph_end;
    exec_state_t state;
    logic ext_en;
    logic [15:0] instr;
    logic [15:0] instr2;
    logic [7:0] working_register;
    logic [3:0] bank_select_register;
    logic [11:0] pointer_register [3];
    logic [7:0] status;
    logic [20:0] pc;
    logic [20:0] return_stack_top;
    logic [7:0] pclath;
    logic [4:0] pclatu;
    logic [7:0] maddr;
    logic [7:0] mem [256];
    logic bad;
    op_t last_op;
    logic [11:0] last_ea;

    logic wr_pend;
    logic [7:0] wr_addr;
    logic rd_wait;
    logic [7:0] rd_addr;
    logic addr_ok;
    logic rd_req;
    logic exec_now;
    logic go;

    logic [11:0] rd_ea;
    logic [7:0] rd_val;
    logic [7:0] xres;
    logic mem_we;
    logic [11:0] mem_wa;
    logic [7:0] mem_wd;
    logic [11:0] next_third_pointer_register;
    logic [20:0] next_pc;

    assign dif.instr = instr;
    assign dif.instr2 = instr2;
    assign dif.ext_en = ext_en;

    op_decoder u_dec (
        .d(dif)
    );

    // Low access half goes through the stack pointer only while the extended set is on
    function automatic logic [11:0] eff_addr(input logic a, input logic [7:0] f, input logic x,
        input logic [11:0] ptr, input logic [3:0] bank);
        if (a) begin
            return {bank, f};
        end else if (x && f <= `ACC_LIMIT) begin
            return ptr + {4'h0, f};
        end else if (f > `ACC_LIMIT) begin
            return {`SFR_BANK, f};
        end
        return {4'h0, f};
    endfunction

    function automatic logic [31:0] rd_mux(input logic [7:0] a);
        case (a)
            `R_CTRL: return {30'h0, ext_en, state != st_idle};
            `R_INSTR: return {instr2, instr};
            `R_WORKING_REGISTER: return {24'h0, working_register};
            `R_BSR: return {28'h0, bank_select_register};
            `R_FSR0: return {20'h0, pointer_register[0]};
            `R_FSR0 + 8'h04: return {20'h0, pointer_register[1]};
            `R_FSR0 + 8'h08: return {20'h0, pointer_register[2]};
            `R_STATUS: return {24'h0, status};
            `R_PC: return {11'h0, pc};
            `R_TOS: return {11'h0, return_stack_top};
            `R_MADDR: return {24'h0, maddr};
            `R_MDATA: return {24'h0, mem[maddr]};
            `R_EXEC: return {4'h0, last_ea, 8'h0, last_op, 2'h0, bad, state != st_idle};
            `R_PCLAT: return {19'h0, pclatu, pclath};
            default: return 32'h0;
        endcase
    endfunction

    // Bus side: zero wait states except one stall for a read right behind a write
    assign addr_ok = hsel && htrans[1] && hready;
    assign rd_req = addr_ok && !hwrite;
    assign go = wr_pend && (wr_addr == `R_CTRL) && hwdata[`CTRL_GO] && (state == st_idle);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
        end else begin
            wr_pend <= addr_ok && hwrite;
            wr_addr <= haddr[7:0];
        end
    end

    // Read captured one cycle late if a write lands in the same cycle, so it sees the new value
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_wait <= 1'b0;
            rd_addr <= 8'h00;
            hrdata <= 32'h0;
            hreadyout <= 1'b1;
            // Only OKAY is ever answered, so the response stays low
            hresp <= 1'b0;
        end else if (rd_wait) begin
            hrdata <= rd_mux(rd_addr);
            rd_wait <= 1'b0;
            hreadyout <= 1'b1;
        end else if (rd_req && wr_pend) begin
            rd_wait <= 1'b1;
            rd_addr <= haddr[7:0];
            hreadyout <= 1'b0;
        end else if (rd_req) begin
            hrdata <= rd_mux(haddr[7:0]);
        end
    end

    // Four clock phases make one instruction cycle
    // Free-running, so a go waits one to four clocks for its slot
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phase <= 2'h0;
        end else begin
            phase <= phase + 2'h1;
        end
    end
    assign ph_end = (phase == `LAST_PHASE);
    assign exec_now = (state == st_cyc1) && ph_end;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= st_idle;
        end else begin
            unique case (state)
                st_idle: if (go) begin
                    state <= st_cyc1;
                end
                st_cyc1: if (ph_end) begin
                    state <= dif.two_cycle ? st_cyc2 : st_idle;
                end
                st_cyc2: if (ph_end) begin
                    state <= st_idle;
                end
                default: state <= st_idle;
            endcase
        end
    end

    // Execute datapath
    always_comb begin
        rd_ea = eff_addr(dif.bank_sel, dif.faddr, ext_en, pointer_register[`PTR_STACK], bank_select_register);
        if (dif.op == indexed_to_absolute_move || dif.op == indexed_to_indexed_move) begin
            rd_ea = pointer_register[`PTR_STACK] + {5'h0, dif.zsrc};
        end
        rd_val = mem[rd_ea[7:0]];
        xres = working_register ^ rd_val;
        mem_we = 1'b0;
        mem_wa = rd_ea;
        mem_wd = xres;
        next_third_pointer_register = pointer_register[`PTR_STACK];
        next_pc = pc + `PC_STEP;
        unique case (dif.op)
            xor_w_into_file: mem_we = dif.dest_file;
            stack_pointer_add_and_return: begin
                next_third_pointer_register = pointer_register[`PTR_STACK] + {6'h0, dif.lit6};
                next_pc = return_stack_top;
            end
            stack_pointer_sub_and_return: begin
                next_third_pointer_register = pointer_register[`PTR_STACK] - {6'h0, dif.lit6};
                next_pc = return_stack_top;
            end
            call_via_working_reg: next_pc = {pclatu, pclath, working_register};
            indexed_to_absolute_move: begin
                mem_we = dif.second_ok;
                mem_wa = dif.fdst;
                mem_wd = rd_val;
                next_pc = pc + `PC_STEP2;
            end
            indexed_to_indexed_move: begin
                mem_we = dif.second_ok;
                mem_wa = pointer_register[`PTR_STACK] + {5'h0, dif.zdst};
                mem_wd = rd_val;
                next_pc = pc + `PC_STEP2;
            end
            push_literal_to_soft_stack: begin
                mem_we = 1'b1;
                mem_wa = pointer_register[`PTR_STACK];
                mem_wd = dif.lit8;
                next_third_pointer_register = pointer_register[`PTR_STACK] - 12'h001;
            end
            default: ;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ext_en <= `XCFG_RESET;
            instr <= 16'h0000;
            instr2 <= 16'h0000;
        end else if (wr_pend) begin
            if (wr_addr == `R_CTRL) begin
                ext_en <= hwdata[`CTRL_XCFG];
            end
            if (wr_addr == `R_INSTR && state == st_idle) begin
                instr <= hwdata[15:0];
                instr2 <= hwdata[31:16];
            end
        end
    end

    // Execution has priority over a bus write in the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            working_register <= 8'h00;
        end else if (exec_now && dif.op == xor_w_into_file && !dif.dest_file) begin
            working_register <= xres;
        end else if (wr_pend && wr_addr == `R_WORKING_REGISTER) begin
            working_register <= hwdata[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bank_select_register <= 4'h0;
            pclath <= 8'h00;
            pclatu <= 5'h00;
            maddr <= 8'h00;
        end else if (wr_pend) begin
            if (wr_addr == `R_BSR) begin
                bank_select_register <= hwdata[3:0];
            end
            if (wr_addr == `R_PCLAT) begin
                pclath <= hwdata[7:0];
                pclatu <= hwdata[12:8];
            end
            if (wr_addr == `R_MADDR) begin
                maddr <= hwdata[7:0];
            end
        end
    end

    generate
        for (genvar i = 0; i < 3; i++) begin : g_ptr
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    pointer_register[i] <= 12'h000;
                end else if (exec_now && dif.op == pointer_add_literal && dif.psel == 2'(i)) begin
                    pointer_register[i] <= pointer_register[i] + {6'h0, dif.lit6};
                end else if (exec_now && dif.op == pointer_sub_literal && dif.psel == 2'(i)) begin
                    pointer_register[i] <= pointer_register[i] - {6'h0, dif.lit6};
                end else if (exec_now && i == `PTR_STACK) begin
                    pointer_register[i] <= next_third_pointer_register;
                end else if (wr_pend && wr_addr == `R_FSR0 + 8'(4 * i)) begin
                    pointer_register[i] <= hwdata[11:0];
                end
            end
        end
    endgenerate

    // Only N and Z move; the other flags are held across the instruction
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            status <= 8'h00;
        end else if (exec_now && dif.op == xor_w_into_file) begin
            status[`ST_N] <= xres[7];
            status[`ST_Z] <= (xres == 8'h00);
        end else if (wr_pend && wr_addr == `R_STATUS) begin
            status <= hwdata[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pc <= 21'h0;
            return_stack_top <= 21'h0;
        end else if (exec_now) begin
            pc <= next_pc;
            if (dif.op == call_via_working_reg) begin
                return_stack_top <= pc + `PC_STEP;
            end
        end else if (wr_pend) begin
            if (wr_addr == `R_PC) begin
                pc <= hwdata[20:0];
            end
            if (wr_addr == `R_TOS) begin
                return_stack_top <= hwdata[20:0];
            end
        end
    end

    // Data memory holds the low address byte only; upper address bits alias
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int j = 0; j < 256; j++) begin
                mem[j] <= 8'h00;
            end
        end else if (exec_now && mem_we) begin
            mem[mem_wa[7:0]] <= mem_wd;
        end else if (wr_pend && wr_addr == `R_MDATA) begin
            mem[maddr] <= hwdata[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bad <= 1'b0;
            last_op <= op_unsupported;
            last_ea <= 12'h000;
        end else if (go) begin
            bad <= 1'b0;
        end else if (exec_now) begin
            last_op <= dif.op;
            last_ea <= mem_wa;
            bad <= (dif.op == op_unsupported)
                || ((dif.op == indexed_to_absolute_move || dif.op == indexed_to_indexed_move)
                && !dif.second_ok);
        end
    end

    logic unused_ok;
    assign unused_ok = ^{hsize, haddr[31:8]};
endmodule
`default_nettype wire
